// >>> src/rtc_alarm_irq.sv
//============================================================
// Purpose: Alarm compare, pin control, write protect, trim
// Assumes: Byte register port; calendar and tick from outside
// Notes:   Persistent store modelled by reset-held flops
//============================================================
`timescale 1ns/1ps
module rtc_alarm_irq
   import rtc_alarm_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       wr_in,
   input  wire logic       rd_start_in,
   input  wire logic       rd_done_in,
   input  wire logic [8:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       tick_in,
   input  wire logic [7:0] cal_in [ALM_BYTES],
   output logic      [7:0] rdata_out,
   output logic            array_wr_out,
   output logic            irq_or_clockout_pin_out,
   output logic      [5:0] crystal_pin_caps_out,
   output logic            alarm_zero_flag_out,
   output logic            alarm_one_flag_out
);
   default clocking chk_clk @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   //=========================================================
   // Storage
   //=========================================================
   // Reset stands in for the first power-up of the persistent store
   logic [7:0] alm_ff [2][ALM_BYTES];
   logic [7:0] eeprom_protect_control_ff;
   logic [7:0] interrupt_and_clockout_control_ff;
   logic [7:0] analog_crystal_trim_ff;
   logic [1:0] flag_ff;
   logic [1:0] snap_ff;
   logic       hold_ff;
   logic [3:0] pulse_ff;

   //=========================================================
   // Decode
   //=========================================================
   logic [2:0] protect_select;
   logic       pulsed_irq_mode;
   logic [1:0] irq_en;
   fsel_t      clockout_select;
   logic       prot_hit;
   logic       alm_area;
   logic       alm_sel;
   logic [2:0] alm_idx;
   logic [1:0] match;
   logic       alarm_path;
   logic       w32k, w4k, w1;
   logic       nxt_pin;
   logic [7:0] nxt_rdata;

   assign protect_select  = eeprom_protect_control_ff[PR_SEL_HI:PR_SEL_LO];
   assign pulsed_irq_mode = interrupt_and_clockout_control_ff[IC_PULSE_BIT];
   assign irq_en = {interrupt_and_clockout_control_ff[IC_EN1_BIT],
                    interrupt_and_clockout_control_ff[IC_EN0_BIT]};
   assign clockout_select = fsel_t'(
      interrupt_and_clockout_control_ff[IC_FSEL_HI:IC_FSEL_LO]);

   function automatic logic in_range(input logic [8:0] a,
                                     input logic [8:0] lo,
                                     input logic [8:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   always_comb
   begin
      unique case (protect_select)
         3'h0: prot_hit = 1'b0;
         3'h1: prot_hit = in_range(addr_in, UP_QTR_LO, TOP_ADDR);
         3'h2: prot_hit = in_range(addr_in, UP_HALF_LO, TOP_ADDR);
         3'h4: prot_hit = in_range(addr_in, 9'h000, P4_HI);
         3'h5: prot_hit = in_range(addr_in, 9'h000, P8_HI);
         3'h6: prot_hit = in_range(addr_in, 9'h000, P16_HI);
         default: prot_hit = 1'b1;
      endcase
   end

   assign alm_area = (addr_in < PROTECT_OFS);
   assign alm_sel  = addr_in[3];
   assign alm_idx  = addr_in[2:0];

   // Enabled fields must equal; year byte is skipped
   function automatic logic alarm_match(input logic [7:0] a [ALM_BYTES],
                                        input logic [7:0] c [ALM_BYTES]);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < ALM_BYTES; i++)
         if (i != ALM_YEAR_IDX && a[i][ALM_EN_BIT]
             && a[i][6:0] != c[i][6:0])
            ok = 1'b0;
      return ok;
   endfunction

   assign match[0] = tick_in && alarm_match(alm_ff[0], cal_in);
   assign match[1] = tick_in && alarm_match(alm_ff[1], cal_in);

   assign alarm_path = (clockout_select == FSEL_ALARM);

   always_comb
   begin
      unique case (clockout_select)
         FSEL_ALARM: nxt_pin = ~(hold_ff || (pulse_ff != 4'h0));
         FSEL_32K:   nxt_pin = w32k;
         FSEL_4K:    nxt_pin = w4k;
         FSEL_1HZ:   nxt_pin = w1;
      endcase
   end

   always_comb
   begin
      nxt_rdata = 8'h00;
      if (addr_in == STATUS_OFS)
      begin
         nxt_rdata[ST_AL1_BIT] = flag_ff[1];
         nxt_rdata[ST_AL0_BIT] = flag_ff[0];
         nxt_rdata[ST_ZERO_BIT] = 1'b0;
      end
      else if (alm_area && alm_idx != 3'h7)
         nxt_rdata = alm_ff[alm_sel][alm_idx];
      else if (addr_in == PROTECT_OFS)
         nxt_rdata = eeprom_protect_control_ff;
      else if (addr_in == IRQCTL_OFS)
         nxt_rdata = interrupt_and_clockout_control_ff;
      else if (addr_in == TRIM_OFS)
         nxt_rdata = analog_crystal_trim_ff;
   end

   //=========================================================
   // Registers
   //=========================================================
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         eeprom_protect_control_ff         <= PROTECT_RST;
         interrupt_and_clockout_control_ff <= IRQCTL_RST;
         analog_crystal_trim_ff            <= TRIM_RST;
      end
      else if (wr_in && !prot_hit)
      begin
         if (addr_in == PROTECT_OFS)
            eeprom_protect_control_ff <= wdata_in;
         if (addr_in == IRQCTL_OFS)
            interrupt_and_clockout_control_ff <= wdata_in;
         if (addr_in == TRIM_OFS)
            analog_crystal_trim_ff <= {2'b00, wdata_in[5:0]};
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         for (int s = 0; s < 2; s++)
            for (int i = 0; i < ALM_BYTES; i++)
               alm_ff[s][i] <= ALM_RST;
      end
      else if (wr_in && !prot_hit && alm_area && alm_idx != 3'h7)
         alm_ff[alm_sel][alm_idx] <= wdata_in;
   end

   // Set wins: a match during the clearing read survives it
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         flag_ff <= 2'b00;
         snap_ff <= 2'b00;
      end
      else
      begin
         if (rd_start_in && addr_in == STATUS_OFS)
            snap_ff <= flag_ff;
         flag_ff <= (flag_ff & ~(rd_done_in ? snap_ff : 2'b00))
                    | match;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         hold_ff  <= 1'b0;
         pulse_ff <= 4'h0;
      end
      else
      begin
         if (!pulsed_irq_mode && alarm_path && |(match & irq_en))
            hold_ff <= 1'b1;
         else if (rd_done_in && |snap_ff || pulsed_irq_mode)
            hold_ff <= 1'b0;
         if (pulsed_irq_mode && alarm_path && |(match & irq_en))
            pulse_ff <= 4'(PULSE_CYC);
         else if (pulse_ff != 4'h0)
            pulse_ff <= pulse_ff - 4'h1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         irq_or_clockout_pin_out <= 1'b1;
         crystal_pin_caps_out    <= 6'h00;
         alarm_zero_flag_out     <= 1'b0;
         alarm_one_flag_out      <= 1'b0;
         array_wr_out            <= 1'b0;
         rdata_out               <= 8'h00;
      end
      else
      begin
         irq_or_clockout_pin_out <= nxt_pin;
         crystal_pin_caps_out    <= analog_crystal_trim_ff[5:0];
         alarm_zero_flag_out     <= flag_ff[0];
         alarm_one_flag_out      <= flag_ff[1];
         array_wr_out            <= wr_in && !prot_hit;
         rdata_out               <= nxt_rdata;
      end
   end

   //=========================================================
   // Clock output dividers
   //=========================================================
   clk_divider #(.HALF_CYC(HALF32K_CYC)) u_d32k
   (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .run_in   (clockout_select == FSEL_32K),
      .wave_out (w32k)
   );
   clk_divider #(.HALF_CYC(HALF4K_CYC)) u_d4k
   (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .run_in   (clockout_select == FSEL_4K),
      .wave_out (w4k)
   );
   clk_divider #(.HALF_CYC(HALF1_CYC)) u_d1
   (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .run_in   (clockout_select == FSEL_1HZ),
      .wave_out (w1)
   );

   //=========================================================
   // Checks
   //=========================================================
   a_status_zero_bit: assert property (
      (addr_in == STATUS_OFS) |=> rdata_out[ST_ZERO_BIT] == 1'b0)
      else $error("status bit 3 not zero");
   a_match_sets_flag: assert property (
      match[0] |=> flag_ff[0])
      else $error("alarm zero flag missed");
   a_flag_one_set: assert property (
      match[1] |=> ##1 alarm_one_flag_out)
      else $error("alarm one flag output missed");
   a_no_tick_match: assert property (
      !tick_in |-> match == 2'b00)
      else $error("match without tick");
   a_prot_write_drop: assert property (
      (wr_in && prot_hit) |=> !array_wr_out)
      else $error("protected write passed");
   a_full_lock: assert property (
      (protect_select[1:0] == 2'b11) |-> prot_hit)
      else $error("full lock not protecting");
   a_hold_low_pin: assert property (
      (alarm_path && !pulsed_irq_mode && |(match & irq_en))
      |=> ##1 !irq_or_clockout_pin_out)
      else $error("single event pin not low");
   a_pulse_width: assert property (
      (alarm_path && pulsed_irq_mode && |(match & irq_en))
      |=> ##1 !irq_or_clockout_pin_out [*8] ##1 irq_or_clockout_pin_out)
      else $error("pulse width wrong");
   a_trim_out: assert property (
      ##1 crystal_pin_caps_out == $past(analog_crystal_trim_ff[5:0]))
      else $error("trim output stale");
endmodule

// >>> shared/rtc_alarm_pkg.sv
//============================================================
// Purpose: Constants for alarm, pin control, protect and trim
// Assumes: Byte-wide register port, 125 MHz clock
// Notes:   Offsets are the device's own byte addresses
//============================================================
package rtc_alarm_pkg;
   // Register offsets
   localparam logic [8:0] ALM0_BASE      = 9'h000;
   localparam logic [8:0] ALM1_BASE      = 9'h008;
   localparam logic [8:0] PROTECT_OFS    = 9'h010;
   localparam logic [8:0] IRQCTL_OFS     = 9'h011;
   localparam logic [8:0] TRIM_OFS       = 9'h012;
   localparam logic [8:0] STATUS_OFS     = 9'h03F;
   // Alarm byte indexes within an alarm block
   localparam int         ALM_YEAR_IDX   = 5;
   localparam int         ALM_BYTES      = 7;
   // Field positions
   localparam int         ALM_EN_BIT     = 7;
   localparam int         ST_AL1_BIT     = 6;
   localparam int         ST_AL0_BIT     = 5;
   localparam int         ST_ZERO_BIT    = 3;
   localparam int         IC_PULSE_BIT   = 7;
   localparam int         IC_EN1_BIT     = 6;
   localparam int         IC_EN0_BIT     = 5;
   localparam int         IC_FSEL_HI     = 4;
   localparam int         IC_FSEL_LO     = 3;
   localparam int         PR_SEL_HI      = 7;
   localparam int         PR_SEL_LO      = 5;
   // Reset values
   localparam logic [7:0] PROTECT_RST    = 8'h18;
   localparam logic [7:0] IRQCTL_RST     = 8'h00;
   localparam logic [7:0] TRIM_RST       = 8'h00;
   localparam logic [7:0] ALM_RST        = 8'h00;
   // Protect range bounds
   localparam logic [8:0] TOP_ADDR       = 9'h1FF;
   localparam logic [8:0] UP_QTR_LO      = 9'h180;
   localparam logic [8:0] UP_HALF_LO     = 9'h100;
   localparam logic [8:0] P4_HI          = 9'h03F;
   localparam logic [8:0] P8_HI          = 9'h07F;
   localparam logic [8:0] P16_HI         = 9'h0FF;
   // Clock output rates
   localparam int         CLK_HZ         = 125_000_000;
   localparam int         F32K_HZ        = 32_768;
   localparam int         F4K_HZ         = 4_096;
   localparam int         F1_HZ          = 1;
   localparam int         HALF32K_CYC    = CLK_HZ / (2 * F32K_HZ);
   localparam int         HALF4K_CYC     = CLK_HZ / (2 * F4K_HZ);
   localparam int         HALF1_CYC      = CLK_HZ / (2 * F1_HZ);
   // Pulse width on the pin in pulsed mode
   localparam int         PULSE_NS       = 64;
   localparam int         PULSE_CYC      = PULSE_NS / 8;
   typedef enum logic [1:0] {FSEL_ALARM, FSEL_32K, FSEL_4K, FSEL_1HZ}
      fsel_t;
endpackage

// >>> src/clk_divider.sv
//============================================================
// Purpose: Square wave generator for the clock output choices
// Assumes: Half period given in clk_in cycles
// Notes:   Restarts on any change of choice
//============================================================
`timescale 1ns/1ps
module clk_divider
   import rtc_alarm_pkg::*;
#(
   parameter int HALF_CYC = HALF1_CYC
)
(
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic run_in,
   output logic      wave_out
);
   logic [26:0] cnt_ff;
   logic        nxt_wrap;

   assign nxt_wrap = (cnt_ff == 27'(HALF_CYC - 1));

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cnt_ff   <= 27'h0;
         wave_out <= 1'b0;
      end
      else if (!run_in)
      begin
         cnt_ff   <= 27'h0;
         wave_out <= 1'b0;
      end
      else if (nxt_wrap)
      begin
         cnt_ff   <= 27'h0;
         wave_out <= ~wave_out;
      end
      else
         cnt_ff <= cnt_ff + 27'h1;
   end
endmodule

// >>> dv/host_model.sv
//============================================================
// Purpose: Host side of the byte register port
// Assumes: Requests launched just after a rising edge
// Notes:   Stands in for the serial host; no bus timing
//============================================================
`timescale 1ns/1ps
module host_model
   import rtc_alarm_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   input  wire logic       array_wr_in,
   output logic            wr_out,
   output logic            rd_start_out,
   output logic            rd_done_out,
   output logic      [8:0] addr_out,
   output logic      [7:0] wdata_out
);
   initial
   begin
      wr_out       = 1'b0;
      rd_start_out = 1'b0;
      rd_done_out  = 1'b0;
      addr_out     = 9'h1FF;
      wdata_out    = 8'h00;
   end
   //============================================================
   // Byte write
   task automatic wr_byte(input logic [8:0] a, input logic [7:0] d,
                          output logic ack);
      @(posedge clk_in);
      wr_out    <= 1'b1;
      addr_out  <= a;
      // Unused status bit always sent as zero
      wdata_out <= (a == STATUS_OFS) ? (d & 8'hF7) : d;
      @(posedge clk_in);
      wr_out    <= 1'b0;
      // Stale data is not left standing after the strobe
      wdata_out <= ~d;
      #1 ack = array_wr_in;
   endtask
   //============================================================
   // Byte read
   task automatic rd_byte(input logic [8:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out     <= a;
      rd_start_out <= (a == STATUS_OFS);
      @(posedge clk_in);
      rd_start_out <= 1'b0;
      #1 d = rdata_in;
      // End of status byte strictly after its start
      if (a == STATUS_OFS)
      begin
         @(posedge clk_in);
         rd_done_out <= 1'b1;
         @(posedge clk_in);
         rd_done_out <= 1'b0;
      end
   endtask
endmodule

// >>> dv/rtc_alarm_irq_tb_top.sv
//============================================================
// Purpose: Self-checking bench for alarm, protect and trim
// Assumes: Seeded random data with fixed corner cases
// Notes:   Only the two faster clock outputs are timed
//============================================================
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      checks_done++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("[FAIL] %s expected %h seen %h", nm, e, g); \
      end \
   end
module rtc_alarm_irq_tb_top
   import rtc_alarm_pkg::*;
;
   logic       clk_in = 1'b0;
   logic       rst_b_in = 1'b0;
   logic       tick = 1'b0;
   logic [7:0] cal [ALM_BYTES] = '{default: 8'h00};
   logic       wr, rd_s, rd_d, awr, pin, flag0, flag1, ack;
   logic [8:0] addr;
   logic [7:0] wdata, rdata, d, sec, v;
   logic [5:0] caps;
   int         mismatches = 0;
   int         checks_done = 0;
   int         cycles = 0;
   int         lows, togs;
   logic [8:0] bnd [10] = '{9'h000, 9'h03E, 9'h040, 9'h07F, 9'h080,
                            9'h0FF, 9'h100, 9'h17F, 9'h180, 9'h1FF};
   always #4 clk_in = ~clk_in;
   host_model host (.clk_in(clk_in), .rdata_in(rdata), .array_wr_in(awr),
      .wr_out(wr), .rd_start_out(rd_s), .rd_done_out(rd_d),
      .addr_out(addr), .wdata_out(wdata));
   rtc_alarm_irq DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .wr_in(wr),
      .rd_start_in(rd_s), .rd_done_in(rd_d), .addr_in(addr),
      .wdata_in(wdata), .tick_in(tick), .cal_in(cal), .rdata_out(rdata),
      .array_wr_out(awr), .irq_or_clockout_pin_out(pin),
      .crystal_pin_caps_out(caps), .alarm_zero_flag_out(flag0),
      .alarm_one_flag_out(flag1));
   //============================================================
   // Helpers
   function automatic logic prot(input logic [2:0] s, input logic [8:0] a);
      case (s)
         3'h1: return a >= 9'h180;
         3'h2: return a >= 9'h100;
         3'h4: return a <= 9'h03F;
         3'h5: return a <= 9'h07F;
         3'h6: return a <= 9'h0FF;
         3'h3, 3'h7: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   task automatic do_reset();
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      repeat (16) @(posedge clk_in);
      rst_b_in <= 1'b1;
   endtask
   task automatic tick_once(input logic [7:0] s);
      @(posedge clk_in);
      cal[0] <= s;
      tick   <= 1'b1;
      @(posedge clk_in);
      tick   <= 1'b0;
   endtask
   // Seconds enabled; year enabled but never equal, so it must not count
   task automatic set_alarm(input logic [8:0] base, input logic [7:0] s);
      host.wr_byte(base, {1'b1, s[6:0]}, ack);
      host.wr_byte(base + 9'h005, 8'hD9, ack);
   endtask
   task automatic watch(input int n);
      logic last;
      lows = 0;
      togs = 0;
      last = pin;
      repeat (n)
      begin
         @(posedge clk_in);
         #1;
         lows += (pin === 1'b0);
         togs += (pin !== last);
         last = pin;
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Hang guard, well above the longest expected run
   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 70000)
      begin
         mismatches++;
         close_out();
      end
   end
   //============================================================
   // Tests
   initial
   begin
      sec = 8'($urandom(32'h5F36));
      cal[5] = 8'h12;
      do_reset();
      host.rd_byte(PROTECT_OFS, d);
      `CHK("protect reset", 8'h18, d)
      host.rd_byte(IRQCTL_OFS, d);
      `CHK("irq ctl reset", 8'h00, d)
      `CHK("pin idle", 1'b1, pin)
      `CHK("caps reset", 6'h00, caps)
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 8'h3F : 8'($urandom_range(0, 63));
         host.wr_byte(TRIM_OFS, v, ack);
         @(posedge clk_in);
         #1;
         `CHK("trim caps", v[5:0], caps)
      end
      $display("test trim done");
      for (int s = 0; s < 8; s++)
      begin
         do_reset();
         host.wr_byte(PROTECT_OFS, {3'(s), 5'h18}, ack);
         bnd[1] = 9'($urandom_range(64, 511));
         foreach (bnd[j])
         begin
            host.wr_byte(bnd[j], (j == 0) ? 8'hA5 : 8'($urandom), ack);
            `CHK("write taken", !prot(3'(s), bnd[j]), ack)
         end
         host.rd_byte(ALM0_BASE, d);
         `CHK("byte kept", prot(3'(s), 9'h000) ? 8'h00 : 8'hA5, d)
      end
      $display("test protect done");
      do_reset();
      sec = {1'b0, 3'($urandom_range(0, 5)), 4'($urandom_range(0, 9))};
      set_alarm(ALM0_BASE, sec);
      host.wr_byte(IRQCTL_OFS, 8'h20, ack);
      tick_once(sec ^ 8'h01);
      watch(4);
      `CHK("no match flag", 1'b0, flag0)
      tick_once(sec);
      watch(3);
      `CHK("match flag", 1'b1, flag0)
      watch(40);
      `CHK("pin held low", 40, lows)
      // Calendar stays on the match with no tick: no second event
      watch(4);
      `CHK("one event only", 1'b1, flag0)
      host.rd_byte(STATUS_OFS, d);
      `CHK("status bit3", 1'b0, d[ST_ZERO_BIT])
      `CHK("status flag", 1'b1, d[ST_AL0_BIT])
      watch(3);
      `CHK("flag cleared", 1'b0, flag0)
      `CHK("pin released", 1'b1, pin)
      host.wr_byte(IRQCTL_OFS, 8'h00, ack);
      tick_once(sec);
      watch(20);
      `CHK("flag unenabled", 1'b1, flag0)
      `CHK("pin unenabled", 0, lows)
      host.rd_byte(STATUS_OFS, d);
      // A match landing inside a status read must outlive that read
      fork
         host.rd_byte(STATUS_OFS, d);
         begin
            @(posedge clk_in);
            tick_once(sec);
         end
      join
      watch(3);
      `CHK("late flag kept", 1'b1, flag0)
      `CHK("late flag unread", 1'b0, d[ST_AL0_BIT])
      $display("test single event done");
      set_alarm(ALM1_BASE, sec ^ 8'h02);
      host.wr_byte(IRQCTL_OFS, 8'hE0, ack);
      for (int k = 0; k < 4; k++)
      begin
         tick_once(k[0] ? (sec ^ 8'h02) : sec);
         watch(30);
         `CHK("pulse width", PULSE_CYC, lows)
      end
      `CHK("alarm one flag", 1'b1, flag1)
      $display("test pulsed done");
      host.wr_byte(IRQCTL_OFS, 8'h28, ack);
      watch(3 * HALF32K_CYC);
      `CHK("32k toggles", 1'b1, togs >= 2)
      host.wr_byte(IRQCTL_OFS, 8'h30, ack);
      watch(3 * HALF4K_CYC);
      `CHK("4k toggles", 1'b1, togs >= 2)
      // Slowest rate: first half period far outlasts this window
      host.rd_byte(STATUS_OFS, d);
      host.wr_byte(IRQCTL_OFS, 8'h38, ack);
      tick_once(sec);
      watch(100);
      `CHK("1hz level", 100, lows)
      `CHK("1hz steady", 0, togs)
      `CHK("flag with clock out", 1'b1, flag0)
      host.wr_byte(IRQCTL_OFS, 8'h20, ack);
      watch(4);
      `CHK("no alarm under clock out", 0, lows)
      $display("test clock out done");
      close_out();
   end
endmodule
